/* File: rtl/itp_timer_prog.sv */
// Interval timer programming, latching and readback top
`timescale 1ns/1ps
`default_nettype none
module itp_timer_prog
   import itp_pkg::*;
#(
   parameter int unsigned NCH = NUM_CH
)
(
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic NRST,
   // Host port bus
   input wire logic [7:0] ADDR,
   input wire logic WR_STB,
   input wire logic RD_STB,
   input wire logic [7:0] WDATA,
   output logic [7:0] RDATA,
   output logic RD_ACK,
   // Counting element status
   input wire logic [16*NCH-1:0] CE_COUNT,
   input wire logic [NCH-1:0] CE_LOADED,
   input wire logic [NCH-1:0] CHANNEL_OUTPUT_PIN,
   // Gates
   input wire logic GATE_CH2,
   input wire logic GATE_CH3,
   output logic [NCH-1:0] CH_GATE,
   // Channel programming to counting element
   output logic [3*NCH-1:0] CH_MODE,
   output logic [NCH-1:0] CH_BCD,
   output logic [16*NCH-1:0] PENDING_COUNT_HOLDER,
   output logic [NCH-1:0] CH_LOAD,
   output logic [NCH-1:0] CH_CTRL_RST
);
   generate
      if (NCH != NUM_CH)
      begin : g_bad_nch
         $error("itp_timer_prog: port map serves exactly four channels");
      end
   endgenerate

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   itp_bus_if #(.NCH(NCH)) bi ();

   itp_cw_dec u_dec (
      .addr(ADDR),
      .wr_stb(WR_STB),
      .rd_stb(RD_STB),
      .wdata(WDATA),
      .bo(bi)
   );

   // ----------------------------------------------------------------
   // Channel state
   // ----------------------------------------------------------------
   itp_chan_t ch_ff [NCH];
   itp_chan_t nxt_ch [NCH];
   logic [NCH-1:0] ld_ff;
   logic [NCH-1:0] nxt_ld;
   logic [NCH-1:0] rst_ff;
   logic [NCH-1:0] nxt_rst;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   logic rdack_ff;
   logic nxt_rdack;
   logic [7:0] rbyte [NCH];

   for (genvar g = 0; g < NCH; g++)
   begin : g_rsel
      itp_rd_sel u_rsel (
         .ch(ch_ff[g]),
         .ce(CE_COUNT[16*g +: 16]),
         .rbyte(rbyte[g])
      );
   end

   always_comb
   begin
      itp_chan_t c;
      c = CH_RST;
      nxt_rdata = RSVD_RDATA;
      nxt_rdack = RD_STB;
      for (int i = 0; i < NCH; i++)
      begin
         c = ch_ff[i];
         nxt_ld[i] = 1'b0;
         nxt_rst[i] = 1'b0;
         if (CE_LOADED[i])
            c.nul = 1'b0;
         if (bi.prog[i])
         begin
            c.mode = bi.data[CW_MODE_HI:CW_MODE_LO];
            c.bcd = bi.data[CW_BCD];
            c.rw = itp_rw_t'(bi.data[CW_RW_HI:CW_RW_LO]);
            c.wr_hi = 1'b0;
            c.rd_hi = 1'b0;
            c.cl = 1'b0;
            c.sl = 1'b0;
            c.nul = 1'b1;
            nxt_rst[i] = 1'b1;
         end
         if (bi.lat_cnt[i] && !ch_ff[i].cl)
         begin
            c.cl = 1'b1;
            c.ol = CE_COUNT[16*i +: 16];
         end
         if (bi.lat_sts[i] && !ch_ff[i].sl)
         begin
            c.sl = 1'b1;
            c.sts = {CHANNEL_OUTPUT_PIN[i], ch_ff[i].nul, ch_ff[i].rw,
                     ch_ff[i].mode, ch_ff[i].bcd};
         end
         if (bi.wr[i])
         begin
            // Mode fields stay untouched here
            case (ch_ff[i].rw)
               RW_LSB:
               begin
                  c.cr = {8'h00, bi.data};
                  nxt_ld[i] = 1'b1;
               end
               RW_MSB:
               begin
                  c.cr = {bi.data, 8'h00};
                  nxt_ld[i] = 1'b1;
               end
               RW_BOTH:
               begin
                  if (!ch_ff[i].wr_hi)
                     c.cr[7:0] = bi.data;
                  else
                     c.cr[15:8] = bi.data;
                  c.wr_hi = !ch_ff[i].wr_hi;
                  nxt_ld[i] = ch_ff[i].wr_hi;
               end
               default:
               begin
               end
            endcase
            if (nxt_ld[i])
               c.nul = 1'b1;
         end
         if (bi.rd[i])
         begin
            nxt_rdata = rbyte[i];
            if (ch_ff[i].sl)
               c.sl = 1'b0;
            else if (ch_ff[i].rw == RW_BOTH && !ch_ff[i].rd_hi)
               c.rd_hi = 1'b1;
            else
            begin
               c.rd_hi = 1'b0;
               c.cl = 1'b0;
            end
         end
         nxt_ch[i] = c;
      end
   end

   always_ff @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
      begin
         for (int i = 0; i < NCH; i++)
            ch_ff[i] <= CH_RST;
         ld_ff <= '0;
         rst_ff <= '0;
         rdata_ff <= RSVD_RDATA;
         rdack_ff <= 1'b0;
      end
      else
      begin
         for (int i = 0; i < NCH; i++)
            ch_ff[i] <= nxt_ch[i];
         ld_ff <= nxt_ld;
         rst_ff <= nxt_rst;
         rdata_ff <= nxt_rdata;
         rdack_ff <= nxt_rdack;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign RDATA = rdata_ff;
   assign RD_ACK = rdack_ff;
   assign CH_LOAD = ld_ff;
   assign CH_CTRL_RST = rst_ff;
   assign CH_GATE = {GATE_CH3, GATE_CH2, 2'b11};

   for (genvar g = 0; g < NCH; g++)
   begin : g_out
      assign CH_MODE[3*g +: 3] = ch_ff[g].mode;
      assign CH_BCD[g] = ch_ff[g].bcd;
      assign PENDING_COUNT_HOLDER[16*g +: 16] = ch_ff[g].cr;
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!NRST);

   a_gate_tied_on: assert property (CH_GATE[1:0] == 2'b11)
      else $error("channel 0 or 1 gate not enabled");

   a_rsvd_reads_fixed: assert property (
      bi.rsvd && RD_STB && !CE_LOADED[0]
         |=> RDATA == RSVD_RDATA && $stable(ch_ff[0]))
      else $error("reserved port read not fixed or had effect");

   a_ch3_own_port: assert property (
      WR_STB && ADDR == ADDR_CWR_LO |-> !bi.prog[NCH-1]
         && !bi.lat_cnt[NCH-1] && !bi.lat_sts[NCH-1])
      else $error("first control port reached channel 3");

   a_low_own_port: assert property (
      WR_STB && ADDR == ADDR_CWR_HI |-> bi.prog[NCH-2:0] == '0
         && bi.lat_cnt[NCH-2:0] == '0 && bi.lat_sts[NCH-2:0] == '0)
      else $error("second control port reached channels 0 to 2");

   for (genvar g = 0; g < NCH; g++)
   begin : g_chk
      sequence s_lo_read;
         bi.rd[g] && !ch_ff[g].sl && ch_ff[g].rw == RW_BOTH
            && !ch_ff[g].rd_hi;
      endsequence
      sequence s_hi_read;
         bi.rd[g] && !ch_ff[g].sl && ch_ff[g].rd_hi;
      endsequence
      sequence s_lo_write;
         bi.wr[g] && ch_ff[g].rw == RW_BOTH && !ch_ff[g].wr_hi;
      endsequence
      sequence s_hi_write;
         bi.wr[g] && ch_ff[g].rw == RW_BOTH && ch_ff[g].wr_hi;
      endsequence

      a_prog_resets_ctl: assert property (
         bi.prog[g] |=> CH_CTRL_RST[g] && !ch_ff[g].cl && !ch_ff[g].sl
            && ch_ff[g].nul)
         else $error("control write did not reset channel");

      a_latch_freezes: assert property (
         bi.lat_cnt[g] && !ch_ff[g].cl && !bi.prog[g]
            |=> ch_ff[g].cl && ch_ff[g].ol == $past(CE_COUNT[16*g +: 16]))
         else $error("latch did not capture count");

      a_relatch_ignored: assert property (
         bi.lat_cnt[g] && ch_ff[g].cl |=> $stable(ch_ff[g].ol))
         else $error("second latch overwrote held count");

      a_mode_kept: assert property (
         bi.wr[g] |=> $stable(ch_ff[g].mode) && $stable(ch_ff[g].rw))
         else $error("count write changed mode");

      a_null_on_load: assert property (
         CH_LOAD[g] |-> ch_ff[g].nul)
         else $error("null count flag not set after count write");

      a_status_first: assert property (
         bi.rd[g] && ch_ff[g].sl
            |=> RDATA == $past(ch_ff[g].sts) && !ch_ff[g].sl)
         else $error("status not returned first");

      a_two_byte_read: assert property (
         s_lo_read ##1 !bi.prog[g] ##1 s_hi_read
            |=> !ch_ff[g].rd_hi && !ch_ff[g].cl)
         else $error("two byte read did not release latch");

      a_lo_then_hi: assert property (
         s_lo_read |=> ch_ff[g].rd_hi && ch_ff[g].cl == $past(ch_ff[g].cl))
         else $error("low byte read lost sequencing");

      a_live_low_read: assert property (
         bi.rd[g] && !ch_ff[g].cl && !ch_ff[g].sl && !ch_ff[g].rd_hi
            && ch_ff[g].rw != RW_MSB
            |=> RDATA == $past(CE_COUNT[16*g +: 8]))
         else $error("live read did not return counting element");

      a_held_high_read: assert property (
         bi.rd[g] && ch_ff[g].cl && !ch_ff[g].sl
            && (ch_ff[g].rw == RW_MSB || ch_ff[g].rd_hi)
            |=> RDATA == $past(ch_ff[g].ol[15:8]))
         else $error("latched high byte not returned");

      a_status_kept: assert property (
         bi.lat_sts[g] && ch_ff[g].sl |=> $stable(ch_ff[g].sts))
         else $error("second status latch overwrote held status");

      a_rd_keeps_wrseq: assert property (
         bi.rd[g] |=> $stable(ch_ff[g].wr_hi))
         else $error("read disturbed write byte sequencing");

      a_wr_keeps_rdseq: assert property (
         bi.wr[g] |=> $stable(ch_ff[g].rd_hi))
         else $error("write disturbed read byte sequencing");

      a_first_byte_waits: assert property (
         s_lo_write |=> !CH_LOAD[g] && ch_ff[g].wr_hi)
         else $error("count loaded after low byte only");

      a_pair_loads: assert property (
         s_lo_write ##1 !bi.prog[g] ##1 s_hi_write |=> CH_LOAD[g])
         else $error("count not loaded after high byte");
   end
endmodule : itp_timer_prog
`default_nettype wire

/* File: rtl/itp_pkg.sv */
// Constants and types for the interval timer programming and readback block
// ----------------------------------------------------------------------
// Operation
// - Ports 40H-42H address channels 0-2; 43H is their control port.
// - Port 44H is channel 3, 47H its control port; 45H, 46H reserved.
// - Count ports are 8 bits, using low, high or low-then-high byte order.
// - First control port governs channels 0-2; second governs channel 3.
// - Control word sets channel, mode, binary or BCD, and byte order.
// - Writing a count never alters the channel's programmed mode.
// - Control word write resets channel control at once, defines output.
// - Plain read returns live count; valid only with timer clock held.
// - Only channels 2 and 3 have external gates; 0 and 1 tied on.
// - Latch command has its own two-bit code plus channel bits.
// - Latch freezes count until fully read or reprogrammed.
// - Repeated latch before reading is ignored; first value kept.
// - Latched count read in programmed format; other channels may interleave.
// - Read and write byte order tracked separately per channel.
// - Read-back selects several channels; each unlatches on its own.
// - Repeated read-back count latch before reading is ignored.
// - Read-back can latch status with mode and output pin level.
// - Status has null-count flag until count reaches counting element.
// - With status and count latched, status reads first, then count.
// ----------------------------------------------------------------------
package itp_pkg;
   localparam int unsigned NUM_CH = 4;
   localparam logic [7:0] ADDR_CH0 = 8'h40;
   localparam logic [7:0] ADDR_CH1 = 8'h41;
   localparam logic [7:0] ADDR_CH2 = 8'h42;
   localparam logic [7:0] ADDR_CWR_LO = 8'h43;
   localparam logic [7:0] ADDR_CH3 = 8'h44;
   localparam logic [7:0] ADDR_RSVD_A = 8'h45;
   localparam logic [7:0] ADDR_RSVD_B = 8'h46;
   localparam logic [7:0] ADDR_CWR_HI = 8'h47;
   localparam logic [7:0] RSVD_RDATA = 8'h00;
   // Control word fields
   localparam int unsigned CW_SC_HI = 7;
   localparam int unsigned CW_SC_LO = 6;
   localparam int unsigned CW_RW_HI = 5;
   localparam int unsigned CW_RW_LO = 4;
   localparam int unsigned CW_MODE_HI = 3;
   localparam int unsigned CW_MODE_LO = 1;
   localparam int unsigned CW_BCD = 0;
   localparam int unsigned RB_NCOUNT = 5;
   localparam int unsigned RB_NSTATUS = 4;
   localparam int unsigned RB_SEL_CH0 = 1;
   localparam int unsigned RB_SEL_CH2 = 3;
   localparam logic [1:0] SC_READBACK = 2'h3;
   localparam logic [1:0] SC_CH3 = 2'h0;
   typedef enum logic [1:0] {
      RW_LATCH = 2'b00,
      RW_LSB = 2'b01,
      RW_MSB = 2'b10,
      RW_BOTH = 2'b11
   } itp_rw_t;
   typedef struct packed {
      logic [2:0] mode;
      logic bcd;
      itp_rw_t rw;
      logic wr_hi;
      logic rd_hi;
      logic cl;
      logic [15:0] ol;
      logic sl;
      logic [7:0] sts;
      logic [15:0] cr;
      logic nul;
   } itp_chan_t;
   localparam itp_chan_t CH_RST = '0;
endpackage : itp_pkg

/* File: rtl/itp_bus_if.sv */
// Decoded port access carried from the decoder to the channel core
`timescale 1ns/1ps
`default_nettype none
interface itp_bus_if #(parameter int unsigned NCH = 4);
   logic [NCH-1:0] wr;
   logic [NCH-1:0] rd;
   logic [NCH-1:0] prog;
   logic [NCH-1:0] lat_cnt;
   logic [NCH-1:0] lat_sts;
   logic rsvd;
   logic [7:0] data;
   modport dec (output wr, rd, prog, lat_cnt, lat_sts, rsvd, data);
   modport core (input wr, rd, prog, lat_cnt, lat_sts, rsvd, data);
endinterface : itp_bus_if
`default_nettype wire

/* File: rtl/itp_cw_dec.sv */
// Port address and control word decoder
`timescale 1ns/1ps
`default_nettype none
module itp_cw_dec
   import itp_pkg::*;
(
   // Host port access
   input wire logic [7:0] addr,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [7:0] wdata,
   // Decoded access
   itp_bus_if.dec bo
);
   function automatic logic [3:0] one_hot(input logic [1:0] idx);
      one_hot = 4'h1 << idx;
   endfunction : one_hot

   logic [1:0] sc;
   logic [1:0] rw;
   logic [3:0] rbsel;

   assign sc = wdata[CW_SC_HI:CW_SC_LO];
   assign rw = wdata[CW_RW_HI:CW_RW_LO];
   assign bo.data = wdata;

   always_comb
   begin
      bo.wr = '0;
      bo.rd = '0;
      bo.prog = '0;
      bo.lat_cnt = '0;
      bo.lat_sts = '0;
      bo.rsvd = 1'b0;
      rbsel = '0;
      if (addr == ADDR_CH0 || addr == ADDR_CH1 || addr == ADDR_CH2)
      begin
         bo.wr = wr_stb ? one_hot(addr[1:0]) : 4'h0;
         bo.rd = rd_stb ? one_hot(addr[1:0]) : 4'h0;
      end
      else if (addr == ADDR_CH3)
      begin
         bo.wr = wr_stb ? one_hot(2'h3) : 4'h0;
         bo.rd = rd_stb ? one_hot(2'h3) : 4'h0;
      end
      else if (addr == ADDR_CWR_LO && wr_stb)
      begin
         if (sc == SC_READBACK)
         begin
            rbsel = {1'b0, wdata[RB_SEL_CH2:RB_SEL_CH0]};
            bo.lat_cnt = wdata[RB_NCOUNT] ? 4'h0 : rbsel;
            bo.lat_sts = wdata[RB_NSTATUS] ? 4'h0 : rbsel;
         end
         else if (rw == RW_LATCH)
            bo.lat_cnt = one_hot(sc);
         else
            bo.prog = one_hot(sc);
      end
      else if (addr == ADDR_CWR_HI && wr_stb)
      begin
         if (sc == SC_READBACK)
         begin
            rbsel = {wdata[RB_SEL_CH0], 3'h0};
            bo.lat_cnt = wdata[RB_NCOUNT] ? 4'h0 : rbsel;
            bo.lat_sts = wdata[RB_NSTATUS] ? 4'h0 : rbsel;
         end
         else if (sc == SC_CH3 && rw == RW_LATCH)
            bo.lat_cnt = one_hot(2'h3);
         else if (sc == SC_CH3)
            bo.prog = one_hot(2'h3);
      end
      else if (addr == ADDR_RSVD_A || addr == ADDR_RSVD_B)
         bo.rsvd = wr_stb | rd_stb;
   end
endmodule : itp_cw_dec
`default_nettype wire

/* File: rtl/itp_rd_sel.sv */
// Byte selection for one channel's count port read
`timescale 1ns/1ps
`default_nettype none
module itp_rd_sel
   import itp_pkg::*;
(
   // Channel state
   input wire itp_chan_t ch,
   input wire logic [15:0] ce,
   // Byte returned
   output logic [7:0] rbyte
);
   logic [15:0] val;

   // Held value while latched, live counting element otherwise
   assign val = ch.cl ? ch.ol : ce;

   always_comb
   begin
      if (ch.sl)
         rbyte = ch.sts;
      else if (ch.rw == RW_MSB)
         rbyte = val[15:8];
      else if (ch.rw == RW_BOTH && ch.rd_hi)
         rbyte = val[15:8];
      else
         rbyte = val[7:0];
   end
endmodule : itp_rd_sel
`default_nettype wire

/* File: tb/itp_host_model.sv */
// Host processor model issuing port reads and writes
`timescale 1ns/1ps
`default_nettype none
module itp_host_model
(
   // Port bus
   input wire logic clk,
   output logic [7:0] addr,
   output logic wr_stb,
   output logic rd_stb,
   output logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic rd_ack
);
   initial
   begin
      addr = 8'h00;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      wdata = 8'h00;
   end

   // One write per call; callers keep control word first, pairs whole
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      addr = a;
      wdata = d;
      wr_stb = 1'b1;
      @(posedge clk);
      #1;
      wr_stb = 1'b0;
      wdata = ~d;
   endtask : wr

   // One read; callers may put other port accesses between a channel's two bytes
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic ack);
      @(posedge clk);
      #1;
      addr = a;
      rd_stb = 1'b1;
      @(posedge clk);
      #1;
      rd_stb = 1'b0;
      d = rdata;
      ack = rd_ack;
   endtask : rd
endmodule : itp_host_model
`default_nettype wire

/* File: tb/itp_timer_prog_tb.sv */
// Self-checking testbench for the timer programming and readback top
`timescale 1ns/1ps
`default_nettype none
module itp_timer_prog_tb;
   import itp_pkg::*;
   logic clk_sys, nrst, wr_stb, rd_stb, ack, gate_ch2, gate_ch3;
   logic [7:0] addr, wdata, rdata, d, lo, hi;
   logic rd_ack;
   logic [63:0] ce_count, pch;
   logic [3:0] ce_loaded, out_pin, ch_gate, ch_bcd, ch_load, ch_ctrl_rst;
   logic [11:0] ch_mode;
   logic [31:0] lf;
   logic [15:0] cnt;
   logic [7:0] exp_q[$];
   int num_errors, total_checks, cycles;

   itp_timer_prog dut (.CLK_SYS(clk_sys), .NRST(nrst), .ADDR(addr),
      .WR_STB(wr_stb), .RD_STB(rd_stb), .WDATA(wdata), .RDATA(rdata),
      .RD_ACK(rd_ack), .CE_COUNT(ce_count), .CE_LOADED(ce_loaded),
      .CHANNEL_OUTPUT_PIN(out_pin), .GATE_CH2(gate_ch2),
      .GATE_CH3(gate_ch3), .CH_GATE(ch_gate), .CH_MODE(ch_mode),
      .CH_BCD(ch_bcd), .PENDING_COUNT_HOLDER(pch), .CH_LOAD(ch_load),
      .CH_CTRL_RST(ch_ctrl_rst));
   itp_host_model host (.clk(clk_sys), .addr(addr), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .wdata(wdata), .rdata(rdata), .rd_ack(rd_ack));

   // ----------------------------------------------------------------
   // Clock, timeout, helpers
   // ----------------------------------------------------------------
   initial clk_sys = 1'b0;
   always #50 clk_sys = ~clk_sys;

   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         num_errors++;
         summarize();
      end
   end

   function automatic logic [31:0] nxt_lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : nxt_lfsr

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Read a port and compare with the model's next byte
   task automatic rdq(input logic [7:0] a);
      logic [7:0] e;
      e = exp_q.pop_front();
      host.rd(a, d, ack);
      chk({8'h00, d}, {8'h00, e});
      chk({15'h0, ack}, 16'h0001);
   endtask : rdq

   task automatic summarize();
      $display("checks=%0d errors=%0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      nrst = 1'b0;
      lf = 32'hF578;
      ce_count = 64'h0;
      ce_loaded = 4'h0;
      out_pin = 4'h0;
      gate_ch2 = 1'b0;
      gate_ch3 = 1'b0;
      repeat (20) @(posedge clk_sys);
      #1;
      nrst = 1'b1;
      // Program all channels, then walk modes 0 to 5 on channel 1
      for (int c = 0; c < 4; c++)
      begin
         host.wr((c == 3) ? 8'h47 : 8'h43,
                 {(c == 3) ? 2'b00 : 2'(c), 6'b11_010_0});
         chk({12'h0, ch_ctrl_rst}, 16'(1 << c));
      end
      for (int m = 0; m < 6; m++)
      begin
         host.wr(8'h43, {2'b01, 2'b11, 3'(m), m[0]});
         chk({12'h0, ch_ctrl_rst}, 16'h0002);
         chk({12'h0, ch_mode[5:3], ch_bcd[1]}, 16'({m[2:0], m[0]}));
      end
      $display("test programming done");
      // Two-byte count write on channel 0
      lf = nxt_lfsr(lf);
      host.wr(8'h40, lf[7:0]);
      chk({12'h0, ch_load}, 16'h0000);
      host.wr(8'h40, lf[15:8]);
      chk({12'h0, ch_load}, 16'h0001);
      chk(pch[15:0], lf[15:0]);
      chk({13'h0, ch_mode[2:0]}, 16'h0002);
      $display("test count write done");
      // Latch, ignored relatch, interleaved access
      lf = nxt_lfsr(lf);
      cnt = lf[15:0];
      ce_count = {lf, ~lf};
      ce_count[15:0] = cnt;
      host.wr(8'h43, 8'h00);
      ce_count[15:0] = ~cnt;
      host.wr(8'h43, 8'h00);
      exp_q.push_back(cnt[7:0]);
      exp_q.push_back(ce_count[23:16]);
      exp_q.push_back(cnt[15:8]);
      exp_q.push_back(~cnt[7:0]);
      exp_q.push_back(~cnt[15:8]);
      rdq(8'h40);
      rdq(8'h41);
      lo = lf[23:16];
      hi = lf[31:24];
      host.wr(8'h40, lo);
      rdq(8'h40);
      host.wr(8'h40, hi);
      chk({12'h0, ch_load}, 16'h0001);
      chk(pch[15:0], {hi, lo});
      rdq(8'h40);
      rdq(8'h40);
      $display("test latch done");
      // Read-back with status, null flag, repeated read-back
      out_pin = {3'b000, lf[4]};
      host.wr(8'h43, 8'hC2);
      cnt = ce_count[15:0];
      ce_count[15:0] = cnt + 16'h1111;
      host.wr(8'h43, 8'hC2);
      exp_q.push_back({lf[4], 1'b1, 2'b11, 3'd2, 1'b0});
      exp_q.push_back(cnt[7:0]);
      exp_q.push_back(cnt[15:8]);
      rdq(8'h40);
      rdq(8'h40);
      rdq(8'h40);
      @(posedge clk_sys);
      #1;
      ce_loaded = 4'h1;
      @(posedge clk_sys);
      #1;
      ce_loaded = 4'h0;
      host.wr(8'h43, 8'hE2);
      exp_q.push_back({lf[4], 1'b0, 2'b11, 3'd2, 1'b0});
      rdq(8'h40);
      $display("test read-back done");
      // Channel 3 through its own control port
      host.wr(8'h47, 8'h16);
      chk({12'h0, ch_ctrl_rst}, 16'h0008);
      chk({13'h0, ch_mode[11:9]}, 16'h0003);
      host.wr(8'h44, lo);
      chk({12'h0, ch_load}, 16'h0008);
      chk(pch[63:48], {8'h00, lo});
      host.wr(8'h47, 8'h26);
      host.wr(8'h44, hi);
      chk(pch[63:48], {hi, 8'h00});
      host.wr(8'h47, 8'hD2);
      exp_q.push_back(ce_count[63:56]);
      ce_count[63:48] = ~ce_count[63:48];
      rdq(8'h44);
      $display("test channel 3 done");
      // Reserved ports and gates
      host.wr(8'h45, 8'hFF);
      chk({8'h0, ch_load, ch_ctrl_rst}, 16'h0000);
      host.wr(8'h46, 8'h34);
      chk({8'h0, ch_load, ch_ctrl_rst}, 16'h0000);
      exp_q.push_back(RSVD_RDATA);
      exp_q.push_back(RSVD_RDATA);
      rdq(8'h45);
      rdq(8'h46);
      chk(pch[15:0], {hi, lo});
      gate_ch2 = 1'b1;
      #1;
      chk({12'h0, ch_gate}, 16'h0007);
      gate_ch2 = 1'b0;
      gate_ch3 = 1'b1;
      #1;
      chk({12'h0, ch_gate}, 16'h000B);
      $display("test reserved and gates done");
      // Mid-run reset, then a read before any control word
      @(posedge clk_sys);
      #1;
      nrst = 1'b0;
      #1;
      chk(pch[15:0], 16'h0000);
      chk(pch[63:48], 16'h0000);
      chk({4'h0, ch_bcd, ch_mode}, 16'h0000);
      repeat (2) @(posedge clk_sys);
      #1;
      nrst = 1'b1;
      exp_q.push_back(ce_count[7:0]);
      rdq(8'h40);
      $display("test reset done");
      summarize();
   end
endmodule : itp_timer_prog_tb
`default_nettype wire
